// ---- hdl/port9_pin_function_select.sv ----
// Purpose: Port 9 pin multiplexer between port I/O and alternate functions
// Assumes: Selection bits are static after configuration; one clock domain
// Notes: Prohibited codes leave the pin undriven and feed peripherals a zero
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Mode bit 0 port, 1 alternate
// - Pin 15: irq6, timer5 cap0, timer5 out0
// - Pin 14: irq5, timer5 cap1, timer5 out1
// - Pin 13: bit 1 gives irq4
// - Pin 12: bit 1 gives csi3 clock
// - Pin 7 offers three alternate functions
// - Pin 1: key7, uart1 rx, twowire2 clock
// - Pin 0: key6, uart1 tx, twowire2 data
// - Pin 7 code map: csi1 in, timer2
// - Pin 10: bit 1 gives csi3 data in
// - Pin 9: bit 1 gives csi1 clock
// - Pin 8: bit 1 gives csi1 data out
module port9_pin_function_select
  import pin9_mux_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [15:0] i_port9_pin_mode_bit,
  input wire logic [15:0] i_port9_func_extension_bit,
  input wire logic [15:0] i_port9_func_select_bit,
  input wire logic [15:0] i_port_out,
  input wire logic [15:0] i_port_oe,
  input wire pin9_mux_pkg::periph_out_s i_periph,
  input wire logic [15:0] i_pin,
  output logic [15:0] o_pin,
  output logic [15:0] o_pin_oe,
  output logic [15:0] o_port_in,
  output pin9_mux_pkg::periph_in_s o_periph,
  output logic [15:0] o_prohibited
);
  import pin9_mux_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisation
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_meta_d;
  logic rstn_q;
  logic rstn_d;

  // Assertion is immediate; release waits two edges so no flop leaves reset mid-cycle
  always_comb begin
    rst_meta_d = 1'b1;
    rstn_d = rst_meta_q;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rstn_q <= rstn_d;
    end
  end

  // Pads are asynchronous; nothing decodes them before the second flop
  logic [15:0] pin_s;

  pin9_sync #(.W(PORT_W)) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(rstn_q),
    .i_async(i_pin),
    .o_sync(pin_s)
  );

  // ----------------------------------------------------------------
  // Selection decode
  // ----------------------------------------------------------------
  logic [15:0] alt;
  logic [1:0] code [PORT_W];

  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_code
      // Function bits only count while the pin is in alternate mode
      assign alt[g] = i_port9_pin_mode_bit[g];
      assign code[g] = alt[g] ? {i_port9_func_extension_bit[g], i_port9_func_select_bit[g]}
                              : FN_PROHIBIT;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  logic [15:0] pin_d, pin_q;
  logic [15:0] oe_d, oe_q;
  logic [15:0] port_in_d, port_in_q;
  logic [15:0] bad_d, bad_q;
  periph_in_s per_d, per_q;

  always_comb begin
    // Port mode default: port logic owns every pin
    pin_d = i_port_out & ~alt;
    oe_d = i_port_oe & ~alt;
    port_in_d = pin_s;
    bad_d = 16'h0000;
    // Unselected peripheral inputs see 0, so an idle pad cannot fake an edge
    per_d = '0;

    // ------------------------------------------------------------
    // Three-function pins
    // ------------------------------------------------------------
    // Pin 15
    if (code[PIN15] == FN_A) begin
      per_d.ext_irq_in_6 = pin_s[PIN15];
    end else if (code[PIN15] == FN_B) begin
      per_d.timer5_capture_in_0 = pin_s[PIN15];
    end else if (code[PIN15] == FN_C) begin
      pin_d[PIN15] = i_periph.timer5_out_0;
      oe_d[PIN15] = 1'b1;
    end
    // Pin 14
    if (code[PIN14] == FN_A) begin
      per_d.ext_irq_in_5 = pin_s[PIN14];
    end else if (code[PIN14] == FN_B) begin
      per_d.timer5_capture_in_1 = pin_s[PIN14];
    end else if (code[PIN14] == FN_C) begin
      pin_d[PIN14] = i_periph.timer5_out_1;
      oe_d[PIN14] = 1'b1;
    end
    // Pin 7
    if (code[PIN7] == FN_A) begin
      per_d.csi1_serial_in = pin_s[PIN7];
    end else if (code[PIN7] == FN_B) begin
      per_d.timer2_capture_in_0 = pin_s[PIN7];
    end else if (code[PIN7] == FN_C) begin
      pin_d[PIN7] = i_periph.timer2_out_0;
      oe_d[PIN7] = 1'b1;
    end
    // ------------------------------------------------------------
    // Shared serial pins
    // ------------------------------------------------------------
    // Pin 1: key return listens whenever alternate mode is on
    if (alt[PIN1]) begin
      per_d.key_return_in_7 = pin_s[PIN1];
      per_d.uart1_receive_in = pin_s[PIN1];
      per_d.twowire2_clock_line_i = pin_s[PIN1];
      pin_d[PIN1] = 1'b0;
      oe_d[PIN1] = i_periph.twowire2_clock_line_oe;
    end
    // Pin 0: open-drain data wins over uart transmit while it pulls low
    if (alt[PIN0]) begin
      per_d.key_return_in_6 = pin_s[PIN0];
      per_d.twowire2_data_line_i = pin_s[PIN0];
      pin_d[PIN0] = i_periph.twowire2_data_line_oe ? 1'b0 : i_periph.uart1_transmit_out;
      oe_d[PIN0] = 1'b1;
    end
    // ------------------------------------------------------------
    // Single-function pins
    // ------------------------------------------------------------
    // Single-bit pins: extension bit is a don't-care
    if (alt[PIN13] && i_port9_func_select_bit[PIN13]) begin
      per_d.ext_irq_in_4 = pin_s[PIN13];
    end
    if (alt[PIN12] && i_port9_func_select_bit[PIN12]) begin
      per_d.csi3_serial_clock_i = pin_s[PIN12];
      pin_d[PIN12] = i_periph.csi3_serial_clock_o;
      oe_d[PIN12] = i_periph.csi3_serial_clock_oe;
    end
    if (alt[PIN11] && i_port9_func_select_bit[PIN11]) begin
      pin_d[PIN11] = i_periph.csi3_serial_out;
      oe_d[PIN11] = 1'b1;
    end
    if (alt[PIN10] && i_port9_func_select_bit[PIN10]) begin
      per_d.csi3_serial_in = pin_s[PIN10];
    end
    if (alt[PIN9] && i_port9_func_select_bit[PIN9]) begin
      per_d.csi1_serial_clock_i = pin_s[PIN9];
      pin_d[PIN9] = i_periph.csi1_serial_clock_o;
      oe_d[PIN9] = i_periph.csi1_serial_clock_oe;
    end
    if (alt[PIN8] && i_port9_func_select_bit[PIN8]) begin
      pin_d[PIN8] = i_periph.csi1_serial_out;
      oe_d[PIN8] = 1'b1;
    end

    // ------------------------------------------------------------
    // Prohibited codes
    // ------------------------------------------------------------
    // Flag prohibited codes so software misuse is visible
    bad_d[PIN15] = alt[PIN15] && (code[PIN15] == FN_PROHIBIT);
    bad_d[PIN14] = alt[PIN14] && (code[PIN14] == FN_PROHIBIT);
    bad_d[PIN7] = alt[PIN7] && (code[PIN7] == FN_PROHIBIT);
    bad_d[PIN13] = alt[PIN13] && !i_port9_func_select_bit[PIN13];
    bad_d[PIN12] = alt[PIN12] && !i_port9_func_select_bit[PIN12];
    bad_d[PIN11] = alt[PIN11] && !i_port9_func_select_bit[PIN11];
    bad_d[PIN10] = alt[PIN10] && !i_port9_func_select_bit[PIN10];
    bad_d[PIN9] = alt[PIN9] && !i_port9_func_select_bit[PIN9];
    bad_d[PIN8] = alt[PIN8] && !i_port9_func_select_bit[PIN8];
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Every output is a flop, so pad timing does not depend on decode depth
  always_ff @(posedge i_mclk or negedge rstn_q) begin
    if (!rstn_q) begin
      pin_q <= PORT_OUT_RST;
      oe_q <= PORT_OE_RST;
      port_in_q <= 16'h0000;
      bad_q <= 16'h0000;
      per_q <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
      port_in_q <= port_in_d;
      bad_q <= bad_d;
      per_q <= per_d;
    end
  end

  assign o_pin = pin_q;
  assign o_pin_oe = oe_q;
  assign o_port_in = port_in_q;
  assign o_periph = per_q;
  assign o_prohibited = bad_q;
endmodule
`default_nettype wire

// ---- hdl/pin9_mux_pkg.sv ----
// Purpose: Constants and carrier types for the port 9 pin function select block
// Assumes: 16-pin port; selection bits come from configuration ports
// Notes: Function codes pair the extension bit (msb) with the select bit (lsb)
package pin9_mux_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int PORT_W = 16;
  localparam logic [15:0] MODE_RST = 16'hFFFF;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] EXT_RST = 16'h0000;
  localparam logic [15:0] PORT_OUT_RST = 16'h0000;
  localparam logic [15:0] PORT_OE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Pin positions
  // ----------------------------------------------------------------
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int PIN7 = 7;
  localparam int PIN8 = 8;
  localparam int PIN9 = 9;
  localparam int PIN10 = 10;
  localparam int PIN11 = 11;
  localparam int PIN12 = 12;
  localparam int PIN13 = 13;
  localparam int PIN14 = 14;
  localparam int PIN15 = 15;

  // ----------------------------------------------------------------
  // Function codes {extension, select}
  // ----------------------------------------------------------------
  localparam logic [1:0] FN_PROHIBIT = 2'h0;
  localparam logic [1:0] FN_A = 2'h1;
  localparam logic [1:0] FN_B = 2'h2;
  localparam logic [1:0] FN_C = 2'h3;

  // Signals driven by on-chip peripherals toward the pins
  typedef struct packed {
    logic timer5_out_0;
    logic timer5_out_1;
    logic timer2_out_0;
    logic csi1_serial_out;
    logic csi3_serial_out;
    logic uart1_transmit_out;
    logic csi3_serial_clock_o;
    logic csi3_serial_clock_oe;
    logic csi1_serial_clock_o;
    logic csi1_serial_clock_oe;
    logic twowire2_clock_line_oe;
    logic twowire2_data_line_oe;
  } periph_out_s;

  // Signals delivered from the pins to on-chip peripherals
  typedef struct packed {
    logic ext_irq_in_6;
    logic ext_irq_in_5;
    logic ext_irq_in_4;
    logic timer5_capture_in_0;
    logic timer5_capture_in_1;
    logic timer2_capture_in_0;
    logic csi1_serial_in;
    logic csi3_serial_in;
    logic csi3_serial_clock_i;
    logic csi1_serial_clock_i;
    logic key_return_in_7;
    logic key_return_in_6;
    logic uart1_receive_in;
    logic twowire2_clock_line_i;
    logic twowire2_data_line_i;
  } periph_in_s;

endpackage

// ---- hdl/pin9_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Inputs are asynchronous to i_mclk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module pin9_sync #(
  parameter int W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// ---- dv/pin9_mux_properties.sv ----
// Purpose: Concurrent checks for the port 9 pin function select block
// Assumes: One clock; selection outputs follow inputs after one cycle
// Notes: Checks wait until the reset release pipeline has drained
`timescale 1ns/1ps
`default_nettype none
module pin9_mux_properties
  import pin9_mux_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [15:0] i_port9_pin_mode_bit,
  input wire logic [15:0] i_port9_func_extension_bit,
  input wire logic [15:0] i_port9_func_select_bit,
  input wire logic [15:0] i_port_out,
  input wire logic [15:0] i_port_oe,
  input wire pin9_mux_pkg::periph_out_s i_periph,
  input wire logic [15:0] i_pin,
  input wire logic [15:0] o_pin,
  input wire logic [15:0] o_pin_oe,
  input wire logic [15:0] o_port_in,
  input wire pin9_mux_pkg::periph_in_s o_periph,
  input wire logic [15:0] o_prohibited
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic on;
  logic [15:0] m;
  logic [15:0] x;
  logic [15:0] s;
  assign m = i_port9_pin_mode_bit;
  assign x = i_port9_func_extension_bit;
  assign s = i_port9_func_select_bit;
  assign on = up_q == 2'h3;
  // Outputs are zero for two edges after release, so hold checks off
  always_comb up_d = on ? up_q : up_q + 2'h1;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) up_q <= 2'h0;
    else up_q <= up_d;
  end
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  AST_PORT_PIN: assert property (
    on |-> ((o_pin ^ $past(i_port_out)) & ~$past(m)) == 16'h0000) else $error("port pin wrong");
  AST_PORT_OE: assert property (
    on |-> ((o_pin_oe ^ $past(i_port_oe)) & ~$past(m)) == 16'h0000) else $error("port oe wrong");
  AST_P15_OUT: assert property (
    on && $past(m[15] && x[15] && s[15]) |-> o_pin_oe[15] && o_pin[15] ==
    $past(i_periph.timer5_out_0)) else $error("pin 15 timer out wrong");
  AST_P14_BAD: assert property (
    on && $past(m[14] && !x[14] && !s[14]) |-> o_prohibited[14] && !o_pin_oe[14])
    else $error("pin 14 prohibited code wrong");
  AST_P7_OUT: assert property (
    on && $past(m[7] && x[7] && s[7]) |-> o_pin_oe[7] && o_pin[7] ==
    $past(i_periph.timer2_out_0)) else $error("pin 7 timer out wrong");
  AST_P13_BAD: assert property (
    on |-> o_prohibited[13] == $past(m[13] && !s[13])) else $error("pin 13 flag wrong");
  AST_P12_OE: assert property (
    on && $past(m[12] && s[12]) |-> o_pin_oe[12] == $past(i_periph.csi3_serial_clock_oe))
    else $error("pin 12 clock enable wrong");
  AST_P8_OUT: assert property (
    on && $past(m[8] && s[8]) |-> o_pin_oe[8] && o_pin[8] == $past(i_periph.csi1_serial_out))
    else $error("pin 8 data out wrong");
  AST_P0_DRV: assert property (
    on && $past(m[0]) |-> o_pin_oe[0] && o_pin[0] == $past(i_periph.uart1_transmit_out &&
    !i_periph.twowire2_data_line_oe)) else $error("pin 0 drive wrong");
  AST_IRQ6_OFF: assert property (
    on && !$past(m[15] && !x[15] && s[15]) |-> !o_periph.ext_irq_in_6)
    else $error("irq 6 fed while unselected");
endmodule
bind port9_pin_function_select pin9_mux_properties chk (.i_mclk, .i_rstn,
  .i_port9_pin_mode_bit, .i_port9_func_extension_bit, .i_port9_func_select_bit,
  .i_port_out, .i_port_oe, .i_periph, .i_pin, .o_pin, .o_pin_oe, .o_port_in,
  .o_periph, .o_prohibited);
`default_nettype wire

// ---- dv/board_model.sv ----
// Purpose: Board and peripheral side of the port 9 pin mux
// Assumes: Peripheral and board levels come from one bench word
// Notes: A pad the block leaves undriven shows the board level
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin9_mux_pkg::*;
(
  input wire logic [31:0] i_rnd,
  input wire logic [15:0] i_drv,
  input wire logic [15:0] i_drv_oe,
  output var pin9_mux_pkg::periph_out_s o_periph,
  output logic [15:0] o_pad
);
  assign o_periph = periph_out_s'(i_rnd[11:0]);
  assign o_pad = (i_drv & i_drv_oe) | (i_rnd[31:16] & ~i_drv_oe);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the port 9 pin function select block
// Assumes: Inputs change at the falling edge; results queued by the driver
// Notes: Pads of undriven pins read the board level
`timescale 1ns/1ps
`default_nettype none
module tb_top import pin9_mux_pkg::*;;
  typedef struct packed {
    logic [15:0] pin;
    logic [15:0] oe;
    logic [15:0] pro;
    logic [15:0] pad;
    periph_in_s per;
  } exp_s;
  logic i_mclk = 1'h0;
  logic i_rstn = 1'h0;
  logic [15:0] mode, ext, sel, pout, poe, pad, o_pin, o_pin_oe, o_port_in, o_prohibited;
  logic [31:0] brd, r, w1, w2, w3;
  periph_out_s per;
  periph_in_s o_periph;
  exp_s q[$];
  exp_s ex;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 i_mclk = ~i_mclk;
  port9_pin_function_select dut (.i_mclk, .i_rstn, .i_port9_pin_mode_bit(mode),
    .i_port9_func_extension_bit(ext), .i_port9_func_select_bit(sel), .i_port_out(pout),
    .i_port_oe(poe), .i_periph(per), .i_pin(pad), .o_pin, .o_pin_oe, .o_port_in,
    .o_periph, .o_prohibited);
  board_model bm (.i_rnd(brd), .i_drv(o_pin), .i_drv_oe(o_pin_oe), .o_periph(per), .o_pad(pad));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    for (int k = 0; k < 32; k++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction
  function automatic exp_s model(logic [15:0] m, x, s, po, pe, periph_out_s p);
    exp_s e;
    logic [15:0] dv;
    logic [15:0] de;
    dv = 16'h0000;
    de = 16'h0000;
    dv[15] = p.timer5_out_0;
    de[15] = x[15] & s[15];
    dv[14] = p.timer5_out_1;
    de[14] = x[14] & s[14];
    dv[7] = p.timer2_out_0;
    de[7] = x[7] & s[7];
    dv[12] = p.csi3_serial_clock_o;
    de[12] = s[12] & p.csi3_serial_clock_oe;
    dv[11] = p.csi3_serial_out;
    de[11] = s[11];
    dv[9] = p.csi1_serial_clock_o;
    de[9] = s[9] & p.csi1_serial_clock_oe;
    dv[8] = p.csi1_serial_out;
    de[8] = s[8];
    de[1] = p.twowire2_clock_line_oe;
    dv[0] = p.uart1_transmit_out & !p.twowire2_data_line_oe;
    de[0] = 1'h1;
    e.pin = (po & ~m) | (dv & m);
    e.oe = (pe & ~m) | (de & m);
    e.pro = m & ((~(x | s) & 16'hC080) | (~s & 16'h3F00));
    e.pad = 16'h0000;
    e.per = '0;
    return e;
  endfunction
  // Pad levels a peripheral should see; anything unselected reads 0
  function automatic periph_in_s route_exp(logic [15:0] m, x, s, pd);
    periph_in_s v;
    v = '0;
    v.ext_irq_in_6 = m[15] & ~x[15] & s[15] & pd[15];
    v.timer5_capture_in_0 = m[15] & x[15] & ~s[15] & pd[15];
    v.ext_irq_in_5 = m[14] & ~x[14] & s[14] & pd[14];
    v.timer5_capture_in_1 = m[14] & x[14] & ~s[14] & pd[14];
    v.csi1_serial_in = m[7] & ~x[7] & s[7] & pd[7];
    v.timer2_capture_in_0 = m[7] & x[7] & ~s[7] & pd[7];
    v.ext_irq_in_4 = m[13] & s[13] & pd[13];
    v.csi3_serial_clock_i = m[12] & s[12] & pd[12];
    v.csi3_serial_in = m[10] & s[10] & pd[10];
    v.csi1_serial_clock_i = m[9] & s[9] & pd[9];
    v.key_return_in_7 = m[1] & pd[1];
    v.uart1_receive_in = m[1] & pd[1];
    v.twowire2_clock_line_i = m[1] & pd[1];
    v.key_return_in_6 = m[0] & pd[0];
    v.twowire2_data_line_i = m[0] & pd[0];
    return v;
  endfunction
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_periph(input periph_in_s got, input periph_in_s exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hold every input for five falling edges so the three-cycle pad path settles too
  task automatic apply(input logic [15:0] m, x, s, po, pe, input logic [31:0] b);
    exp_s e;
    mode = m;
    ext = x;
    sel = s | (m & 16'h0800);
    pout = po;
    poe = pe;
    brd = b;
    e = model(m, x, sel, po, pe, periph_out_s'(b[11:0]));
    e.pad = (e.pin & e.oe) | (b[31:16] & ~e.oe);
    e.per = route_exp(m, x, sel, e.pad);
    repeat (4) @(negedge i_mclk);
    q.push_back(e);
    @(negedge i_mclk);
  endtask
  always @(posedge i_mclk) begin
    #1;
    if (q.size() > 0) begin
      ex = q.pop_front();
      cmp_word(o_pin & ex.oe, ex.pin & ex.oe);
      cmp_word(o_pin_oe, ex.oe);
      cmp_word(o_prohibited, ex.pro);
      cmp_word(o_port_in, ex.pad);
      cmp_periph(o_periph, ex.per);
    end
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    mode = 16'hFFFF;
    {ext, sel, pout, poe} = 64'h0;
    brd = 32'h00000000;
    r = 32'h00018097;
    repeat (3) @(negedge i_mclk);
    i_rstn = 1'h1;
    repeat (2) @(negedge i_mclk);
    for (int c = 0; c < 4; c++) begin
      r = lfsr(r);
      apply(16'hFFFF, {16{c[1]}}, {16{c[0]}}, 16'h0000, 16'h0000, r);
    end
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        i_rstn = 1'h0;
        repeat (3) @(negedge i_mclk);
        i_rstn = 1'h1;
        repeat (2) @(negedge i_mclk);
      end
      w1 = lfsr(r);
      w2 = lfsr(w1);
      w3 = lfsr(w2);
      r = lfsr(w3);
      apply(i % 4 == 0 ? 16'h0000 : w1[15:0], w1[31:16], w2[15:0], w2[31:16], w3[15:0], r);
    end
    final_report();
  end
endmodule
`default_nettype wire
